//--- logic/flash_cmd_ctrl.sv
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module flash_cmd_ctrl (
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic [3:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [7:0]                    reg_rdata,
  input  wire logic                     array_wr,
  input  wire logic [15:0]              array_wr_addr,
  input  wire logic [15:0]              array_wr_data,
  input  wire logic                     stop_req,
  input  wire logic                     special_mode_pin,
  output logic                          op_start,
  output flash_cmd_pkg::flash_op_s      op_data,
  output logic                          op_abort,
  input  wire logic                     op_done,
  input  wire logic                     op_erased,
  input  wire logic                     op_error,
  output logic                          cfg_rd_req,
  output logic [22:0]                   cfg_rd_addr,
  input  wire logic                     cfg_rd_valid,
  input  wire logic [7:0]               cfg_rd_data,
  output logic [7:0]                    nv_control,
  output logic                          buffer_empty_irq,
  output logic                          complete_irq
);
  logic rst_meta_r;
  logic rst_n;
  logic special_mode;
  logic nv_loaded;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  level_sync u_mode_sync (
    .mclk (mclk),
    .rst_n(rst_n),
    .din  (special_mode_pin),
    .dout (special_mode)
  );

  nv_loader u_nv_loader (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .cfg_rd_valid(cfg_rd_valid),
    .cfg_rd_data (cfg_rd_data),
    .cfg_rd_req  (cfg_rd_req),
    .cfg_rd_addr (cfg_rd_addr),
    .nv_control  (nv_control),
    .nv_loaded   (nv_loaded)
  );

  // Software registers
  logic [7:0]                config_r;
  logic [7:0]                config_nxt;
  logic [7:0]                protect_r;
  logic [7:0]                protect_nxt;
  logic [7:0]                rdata_nxt;

  // Sequence and command state
  flash_cmd_pkg::seq_e       seq_r;
  flash_cmd_pkg::seq_e       seq_nxt;
  flash_cmd_pkg::flash_op_s  build_r;
  flash_cmd_pkg::flash_op_s  build_nxt;
  flash_cmd_pkg::flash_op_s  pend_r;
  flash_cmd_pkg::flash_op_s  pend_nxt;
  flash_cmd_pkg::flash_op_s  act_r;
  flash_cmd_pkg::flash_op_s  act_nxt;
  logic                      pend_full_r;
  logic                      pend_full_nxt;
  logic                      act_busy_r;
  logic                      act_busy_nxt;
  logic                      start_r;
  logic                      start_nxt;
  logic                      abort_r;
  logic                      abort_nxt;

  // Flags
  logic                      cmd_complete_flag_r;
  logic                      cmd_complete_flag_nxt;
  logic                      protection_violation_flag_r;
  logic                      protection_violation_flag_nxt;
  logic                      access_error_flag_r;
  logic                      access_error_flag_nxt;
  logic                      blank_r;
  logic                      blank_nxt;
  logic                      fail_r;
  logic                      fail_nxt;

  logic                      wr_status;
  logic                      wr_command;
  logic                      flags_block;
  logic                      in_sequence;
  logic                      cmd_legal;
  logic                      cmd_modifies;
  logic                      addr_protected;
  logic                      set_violation;
  logic                      set_access_error;
  logic                      set_fail;
  logic                      launch;
  logic [7:0]                status_rd;

  assign wr_status   = reg_wr && (reg_addr == `REG_STATUS);
  assign wr_command  = reg_wr && (reg_addr == `REG_COMMAND);
  assign flags_block = protection_violation_flag_r || access_error_flag_r;
  assign in_sequence = (seq_r != flash_cmd_pkg::SEQ_IDLE);

  always_comb begin
    case (reg_wdata)
      `CMD_ERASE_VERIFY,
      `CMD_DATA_COMPRESS,
      `CMD_PROGRAM,
      `CMD_SECTOR_ERASE,
      `CMD_MASS_ERASE,
      `CMD_SECTOR_ABORT: cmd_legal = 1'b1;
      default:           cmd_legal = 1'b0;
    endcase
  end

  assign cmd_modifies   = (reg_wdata == `CMD_PROGRAM) || (reg_wdata == `CMD_SECTOR_ERASE) ||
                          (reg_wdata == `CMD_MASS_ERASE);
  // Pages at or above the boundary are protected; a zero boundary disables protection
  assign addr_protected = (protect_r != 8'h00) && (build_r.addr[15:8] >= protect_r);

  // Buffer-empty reads as the inverse of the pending slot
  assign launch = wr_status && reg_wdata[`STAT_EMPTY_BIT] &&
                  (seq_r == flash_cmd_pkg::SEQ_CMD) && !flags_block && !pend_full_r;

  always_comb begin
    seq_nxt       = seq_r;
    build_nxt     = build_r;
    pend_nxt      = pend_r;
    pend_full_nxt = pend_full_r;
    act_nxt       = act_r;
    act_busy_nxt  = act_busy_r;
    start_nxt     = 1'b0;
    abort_nxt     = 1'b0;
    blank_nxt     = blank_r;
    set_violation    = 1'b0;
    set_access_error = 1'b0;
    set_fail      = 1'b0;

    // Array write opens a sequence; refused while a flag blocks it
    if (array_wr && !flags_block) begin
      if (in_sequence || pend_full_r) begin
        set_access_error = 1'b1;
        seq_nxt    = flash_cmd_pkg::SEQ_IDLE;
      end else begin
        build_nxt.addr = array_wr_addr;
        build_nxt.data = array_wr_data;
        seq_nxt        = flash_cmd_pkg::SEQ_WORD;
      end
    end

    if (wr_command) begin
      if (seq_r != flash_cmd_pkg::SEQ_WORD || !cmd_legal) begin
        set_access_error = 1'b1;
        seq_nxt    = flash_cmd_pkg::SEQ_IDLE;
      end else if (cmd_modifies && addr_protected) begin
        set_violation = 1'b1;
        seq_nxt   = flash_cmd_pkg::SEQ_IDLE;
      end else begin
        build_nxt.cmd = reg_wdata;
        seq_nxt       = flash_cmd_pkg::SEQ_CMD;
      end
    end

    if (wr_status && !reg_wdata[`STAT_EMPTY_BIT] && in_sequence) begin
      set_access_error = 1'b1;
      seq_nxt    = flash_cmd_pkg::SEQ_IDLE;
    end

    if (launch) begin
      pend_nxt      = build_r;
      pend_full_nxt = 1'b1;
      blank_nxt     = 1'b0;
      seq_nxt       = flash_cmd_pkg::SEQ_IDLE;
    end

    // Abort command only ends a running sector erase
    if (pend_full_r && pend_r.cmd == `CMD_SECTOR_ABORT) begin
      pend_full_nxt = launch;
      if (act_busy_r && !op_done && act_r.cmd == `CMD_SECTOR_ERASE) begin
        abort_nxt  = 1'b1;
        set_access_error = 1'b1;
      end
    end else if (!act_busy_r && pend_full_r) begin
      act_nxt       = pend_r;
      act_busy_nxt  = 1'b1;
      start_nxt     = 1'b1;
      pend_full_nxt = launch;
    end

    if (act_busy_r && op_done) begin
      act_busy_nxt = 1'b0;
      if (act_r.cmd == `CMD_ERASE_VERIFY) begin
        blank_nxt = op_erased;
        set_fail  = !op_erased;
      end
      if (op_error) begin
        set_access_error = 1'b1;
        if (act_r.cmd == `CMD_ERASE_VERIFY || act_r.cmd == `CMD_DATA_COMPRESS) begin
          pend_full_nxt = launch;
        end
      end
    end

    if (stop_req && !cmd_complete_flag_r) begin
      set_access_error = 1'b1;
    end
  end

  // Complete flag follows emptiness of both slots, so a fetched pending keeps it clear
  assign cmd_complete_flag_nxt = !pend_full_nxt && !act_busy_nxt;

  always_comb begin
    protection_violation_flag_nxt = protection_violation_flag_r;
    access_error_flag_nxt         = access_error_flag_r;
    fail_nxt                      = fail_r;
    if (wr_status && reg_wdata[`STAT_VIOL_BIT]) begin
      protection_violation_flag_nxt = 1'b0;
    end
    if (wr_status && reg_wdata[`STAT_ERR_BIT]) begin
      access_error_flag_nxt = 1'b0;
    end
    if (wr_status && special_mode && reg_wdata[`STAT_FAIL_BIT]) begin
      fail_nxt = 1'b0;
    end
    if (set_violation) begin
      protection_violation_flag_nxt = 1'b1;
    end
    if (set_access_error) begin
      access_error_flag_nxt = 1'b1;
    end
    if (set_fail) begin
      fail_nxt = 1'b1;
    end
  end

  always_comb begin
    config_nxt  = config_r;
    protect_nxt = protect_r;
    if (reg_wr && reg_addr == `REG_CONFIG) begin
      config_nxt = reg_wdata & 8'hC0;
    end
    if (reg_wr && reg_addr == `REG_PROTECT) begin
      protect_nxt = reg_wdata;
    end
  end

  always_comb begin
    status_rd                   = 8'h00;
    status_rd[`STAT_EMPTY_BIT]  = !pend_full_r;
    status_rd[`STAT_DONE_BIT]   = cmd_complete_flag_r;
    status_rd[`STAT_VIOL_BIT]   = protection_violation_flag_r;
    status_rd[`STAT_ERR_BIT]    = access_error_flag_r;
    status_rd[`STAT_BLANK_BIT]  = blank_r;
    status_rd[`STAT_FAIL_BIT]   = fail_r && special_mode;
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `REG_CONFIG:     rdata_nxt = config_r;
        `REG_NV_CONTROL: rdata_nxt = nv_control;
        `REG_STATUS:     rdata_nxt = status_rd;
        `REG_COMMAND:    rdata_nxt = build_r.cmd;
        `REG_ADDR_HIGH:  rdata_nxt = build_r.addr[15:8];
        `REG_ADDR_LOW:   rdata_nxt = build_r.addr[7:0];
        `REG_DATA_HIGH:  rdata_nxt = build_r.data[15:8];
        `REG_DATA_LOW:   rdata_nxt = build_r.data[7:0];
        `REG_PROTECT:    rdata_nxt = protect_r;
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      config_r    <= `CONFIG_RESET;
      protect_r   <= `PROTECT_RESET;
      reg_rdata   <= 8'h00;
      seq_r       <= flash_cmd_pkg::SEQ_IDLE;
      build_r     <= '0;
      pend_r      <= '0;
      act_r       <= '0;
      pend_full_r <= 1'b0;
      act_busy_r  <= 1'b0;
      start_r     <= 1'b0;
      abort_r     <= 1'b0;
      cmd_complete_flag_r         <= 1'b1;
      protection_violation_flag_r <= 1'b0;
      access_error_flag_r         <= 1'b0;
      blank_r     <= 1'b0;
      fail_r      <= 1'b0;
    end else begin
      config_r    <= config_nxt;
      protect_r   <= protect_nxt;
      reg_rdata   <= rdata_nxt;
      seq_r       <= seq_nxt;
      build_r     <= build_nxt;
      pend_r      <= pend_nxt;
      act_r       <= act_nxt;
      pend_full_r <= pend_full_nxt;
      act_busy_r  <= act_busy_nxt;
      start_r     <= start_nxt;
      abort_r     <= abort_nxt;
      cmd_complete_flag_r         <= cmd_complete_flag_nxt;
      protection_violation_flag_r <= protection_violation_flag_nxt;
      access_error_flag_r         <= access_error_flag_nxt;
      blank_r     <= blank_nxt;
      fail_r      <= fail_nxt;
    end
  end

  assign op_start = start_r;
  assign op_data  = act_r;
  assign op_abort = abort_r;

  assign buffer_empty_irq = !pend_full_r && config_r[`CFG_EMPTY_IE_BIT];
  assign complete_irq     = cmd_complete_flag_r && config_r[`CFG_DONE_IE_BIT];
endmodule : flash_cmd_ctrl

//--- logic/flash_cmd_map.svh
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// Register indices on the register port
`define REG_CONFIG        4'h0
`define REG_NV_CONTROL    4'h1
`define REG_STATUS        4'h2
`define REG_COMMAND       4'h3
`define REG_ADDR_HIGH     4'h4
`define REG_ADDR_LOW      4'h5
`define REG_DATA_HIGH     4'h6
`define REG_DATA_LOW      4'h7
`define REG_PROTECT       4'h8

// Status bit positions
`define STAT_EMPTY_BIT    7
`define STAT_DONE_BIT     6
`define STAT_VIOL_BIT     5
`define STAT_ERR_BIT      4
`define STAT_BLANK_BIT    2
`define STAT_FAIL_BIT     1

// Config bit positions
`define CFG_EMPTY_IE_BIT  7
`define CFG_DONE_IE_BIT   6

// Reset values
`define CONFIG_RESET      8'h00
`define PROTECT_RESET     8'h00
`define NV_RESET          8'hFF

// Configuration byte location in global Flash space
`define NV_CFG_ADDR       23'h7F_FF0E

// Command codes
`define CMD_ERASE_VERIFY  8'h05
`define CMD_DATA_COMPRESS 8'h06
`define CMD_PROGRAM       8'h20
`define CMD_SECTOR_ERASE  8'h40
`define CMD_MASS_ERASE    8'h41
`define CMD_SECTOR_ABORT  8'h47

`endif

//--- logic/flash_cmd_pkg.sv
package flash_cmd_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_WORD = 3'b010,
    SEQ_CMD  = 3'b100
  } seq_e;

  typedef enum logic [1:0] {
    LD_REQ  = 2'b01,
    LD_DONE = 2'b10
  } load_e;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } flash_op_s;

endpackage : flash_cmd_pkg

//--- logic/level_sync.sv
`timescale 1ns/1ps
module level_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  logic meta_nxt;
  logic out_nxt;

  always_comb begin
    meta_nxt = din;
    out_nxt  = meta_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      dout   <= out_nxt;
    end
  end
endmodule : level_sync

//--- logic/nv_loader.sv
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module nv_loader (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cfg_rd_valid,
  input  wire logic [7:0]  cfg_rd_data,
  output logic             cfg_rd_req,
  output logic [22:0]      cfg_rd_addr,
  output logic [7:0]       nv_control,
  output logic             nv_loaded
);
  flash_cmd_pkg::load_e state_r;
  flash_cmd_pkg::load_e state_nxt;
  logic [7:0]           nv_r;
  logic [7:0]           nv_nxt;

  // Fetch the configuration byte once after reset
  always_comb begin
    state_nxt = state_r;
    nv_nxt    = nv_r;
    case (state_r)
      flash_cmd_pkg::LD_REQ: begin
        if (cfg_rd_valid) begin
          nv_nxt    = cfg_rd_data;
          state_nxt = flash_cmd_pkg::LD_DONE;
        end
      end
      flash_cmd_pkg::LD_DONE: state_nxt = flash_cmd_pkg::LD_DONE;
      default: state_nxt = flash_cmd_pkg::LD_REQ;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= flash_cmd_pkg::LD_REQ;
      nv_r    <= `NV_RESET;
    end else begin
      state_r <= state_nxt;
      nv_r    <= nv_nxt;
    end
  end

  assign cfg_rd_req  = (state_r == flash_cmd_pkg::LD_REQ);
  assign cfg_rd_addr = `NV_CFG_ADDR;
  assign nv_control  = nv_r;
  assign nv_loaded   = (state_r == flash_cmd_pkg::LD_DONE);
endmodule : nv_loader

//--- tb/flash_cmd_ctrl_chk.sv
`timescale 1ns/1ps
module flash_cmd_ctrl_chk (
  input wire logic                     mclk,
  input wire logic                     resetn,
  input wire logic [3:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     op_start,
  input wire flash_cmd_pkg::flash_op_s op_data,
  input wire logic                     op_abort,
  input wire logic                     op_done,
  input wire logic                     cfg_rd_req,
  input wire logic [22:0]              cfg_rd_addr,
  input wire logic                     cfg_rd_valid,
  input wire logic [7:0]               cfg_rd_data,
  input wire logic [7:0]               nv_control,
  input wire logic                     buffer_empty_irq,
  input wire logic                     complete_irq
);
  logic [1:0] irq_en_r;
  logic       busy_r;

  // Shadow of the enables and of an array operation in flight
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_en_r <= 2'b00;
      busy_r   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h0) irq_en_r <= reg_wdata[7:6];
      if (op_start) busy_r <= 1'b1;
      else if (op_done) busy_r <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_CFG_ADDR: assert property (cfg_rd_req |-> cfg_rd_addr == 23'h7f_ff0e)
    else $error("config fetch address wrong");
  AST_NV_LOAD: assert property (cfg_rd_req && cfg_rd_valid |=>
    !cfg_rd_req && nv_control == $past(cfg_rd_data)) else $error("config byte not loaded");
  AST_NV_HOLD: assert property (!cfg_rd_req |=> $stable(nv_control))
    else $error("nonvolatile byte changed after load");
  AST_RD_UNMAPPED: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_RESERVED: assert property (reg_rd && reg_addr == 4'h2 |=>
    reg_rdata[3] == 1'b0 && reg_rdata[0] == 1'b0) else $error("reserved status bits set");
  AST_BUSY_COMPLETE: assert property (reg_rd && reg_addr == 4'h2 && busy_r && !op_done
    |=> !reg_rdata[6]) else $error("complete flag set while busy");
  AST_OP_HOLD: assert property (!op_start |-> $stable(op_data))
    else $error("operation changed without start");
  AST_LEGAL_CMD: assert property (op_start |->
    op_data.cmd inside {8'h05, 8'h06, 8'h20, 8'h40, 8'h41}) else $error("illegal op started");
  AST_ABORT_ERASE: assert property (op_abort |-> busy_r && op_data.cmd == 8'h40)
    else $error("abort without running sector erase");
  AST_IRQ_GATE: assert property (({buffer_empty_irq, complete_irq} & ~irq_en_r) == 2'b00)
    else $error("interrupt without enable");
  AST_IRQ_DROP: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[7:6] == 2'b00
    |-> ##[1:2] !buffer_empty_irq && !complete_irq) else $error("interrupt did not drop");

  COV_ABORT: cover property (op_abort);
  COV_CIRQ: cover property (complete_irq);
  COV_CHAIN: cover property (op_done ##[1:3] op_start);
endmodule : flash_cmd_ctrl_chk

bind flash_cmd_ctrl flash_cmd_ctrl_chk i_flash_cmd_ctrl_chk (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start),
  .op_data(op_data), .op_abort(op_abort), .op_done(op_done), .cfg_rd_req(cfg_rd_req),
  .cfg_rd_addr(cfg_rd_addr), .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data),
  .nv_control(nv_control), .buffer_empty_irq(buffer_empty_irq), .complete_irq(complete_irq));

//--- tb/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model #(
  parameter logic [7:0] CFG_BYTE = 8'h5a
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [7:0] lat,
  input  wire logic       res_erased,
  input  wire logic       res_error,
  input  wire logic       op_start,
  input  wire logic       op_abort,
  output logic            op_done,
  output logic            op_erased,
  output logic            op_error,
  input  wire logic       cfg_rd_req,
  output logic            cfg_rd_valid,
  output logic [7:0]      cfg_rd_data
);
  logic [7:0] cnt_r;
  logic       busy_r;
  logic [2:0] req_r;

  // Result lines show the inverse of a real answer outside a completion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {op_done, op_erased, op_error, cfg_rd_valid, busy_r} <= 5'h00;
      cnt_r       <= 8'h00;
      req_r       <= 3'h0;
      cfg_rd_data <= ~CFG_BYTE;
    end else begin
      op_done      <= 1'b0;
      op_erased    <= ~res_erased;
      op_error     <= ~res_error;
      cfg_rd_valid <= 1'b0;
      cfg_rd_data  <= ~CFG_BYTE;
      req_r        <= (cfg_rd_req && !cfg_rd_valid) ? req_r + 3'h1 : 3'h0;
      if (op_start) begin
        busy_r <= 1'b1;
        cnt_r  <= lat;
      end else if (busy_r && (cnt_r == 8'h00 || op_abort)) begin
        busy_r    <= 1'b0;
        op_done   <= 1'b1;
        op_erased <= res_erased;
        op_error  <= res_error;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
      if (req_r == 3'h6) begin
        cfg_rd_valid <= 1'b1;
        cfg_rd_data  <= CFG_BYTE;
        req_r        <= 3'h0;
      end
    end
  end
endmodule : flash_array_model

//--- tb/flash_command_status_flags_tb_top.sv
`timescale 1ns/1ps
module flash_command_status_flags_tb_top;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic                     mclk, resetn, reg_wr, reg_rd, array_wr, stop_req, special_mode_pin;
  logic                     op_start, op_abort, op_done, op_erased, op_error, res_erased;
  logic                     cfg_rd_req, cfg_rd_valid, buffer_empty_irq, complete_irq, res_error;
  logic [3:0]               reg_addr;
  logic [7:0]               reg_wdata, reg_rdata, cfg_rd_data, nv_control, lat, v;
  logic [15:0]              array_wr_addr, array_wr_data;
  logic [22:0]              cfg_rd_addr;
  flash_cmd_pkg::flash_op_s op_data;
  int                       err_count = 0, checks_done = 0, n_start = 0, ns = 0;
  row_s                     rows [7] = '{{4'h0, 8'hc0, 8'hc0}, {4'h8, 8'h80, 8'h80},
    {4'h8, 8'h00, 8'h00}, {4'h1, 8'h00, 8'h5a}, {4'hf, 8'hff, 8'h00},
    {4'h2, 8'h00, 8'hc0}, {4'h2, 8'h4e, 8'hc0}};

  flash_cmd_ctrl i_flash_cmd_ctrl (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .array_wr(array_wr), .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data),
    .stop_req(stop_req), .special_mode_pin(special_mode_pin), .op_start(op_start),
    .op_data(op_data), .op_abort(op_abort), .op_done(op_done), .op_erased(op_erased),
    .op_error(op_error), .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data), .nv_control(nv_control),
    .buffer_empty_irq(buffer_empty_irq), .complete_irq(complete_irq));
  flash_array_model i_flash_array_model (.mclk(mclk), .resetn(resetn), .lat(lat),
    .res_erased(res_erased), .res_error(res_error), .op_start(op_start),
    .op_abort(op_abort), .op_done(op_done),
    .op_erased(op_erased), .op_error(op_error), .cfg_rd_req(cfg_rd_req),
    .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) if (op_start === 1'b1) n_start <= n_start + 1;

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic drv(input logic [3:0] a, input logic [7:0] d, input logic [3:0] k);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_wr, reg_rd, array_wr, stop_req} <= k;
  endtask : drv

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    drv(a, d, 4'b1000);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    drv(a, 8'h00, 4'b0100);
    drv(4'h0, 8'h00, 4'b0000);
    #1 v = reg_rdata;
  endtask : rd

  // Word, command, then optional launch on consecutive cycles
  task automatic seq(input logic [15:0] a, input logic [7:0] c, input logic go);
    drv(4'h0, 8'h00, 4'b0010);
    array_wr_addr <= a;
    array_wr_data <= ~a;
    drv(4'h3, c, 4'b1000);
    if (go) drv(4'h2, 8'h80, 4'b1000);
    drv(4'h0, 8'h00, 4'b0000);
  endtask : seq

  task automatic wait_out(input logic sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 120 && !hit; i++) begin
      #1 hit = sel ? (op_abort === 1'b1) : (op_start === 1'b1);
      if (!hit) @(posedge mclk);
    end
    if (!hit) begin
      err_count++;
      results();
    end
  endtask : wait_out

  task automatic wait_cc;
    v = 8'h00;
    for (int i = 0; i < 80 && v[6] !== 1'b1; i++) rd(4'h2);
    if (v[6] !== 1'b1) begin
      err_count++;
      results();
    end
  endtask : wait_cc

  initial begin
    {reg_wr, reg_rd, array_wr, stop_req, special_mode_pin, resetn} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    {array_wr_addr, array_wr_data} = 32'h0000_0000;
    lat = 8'h03;
    res_erased = 1'b1;
    res_error = 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (12) @(posedge mclk);
    chk("nv_control", nv_control, 8'h5a);
    rd(4'h2);
    chk("status", v, 8'hc0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("register", v, rows[i].e);
    end
    seq(16'h1234, 8'h20, 1'b1);
    wait_out(1'b0);
    chk("op_data", op_data, {8'h20, 16'h1234, 16'hedcb});
    chk("complete_irq", complete_irq, 1'b0);
    wait_cc;
    chk("irqs", {buffer_empty_irq, complete_irq}, 2'b11);
    wr(4'h4, 8'h00);
    rd(4'h4);
    chk("addr_high", v, 8'h12);
    rd(4'h5);
    chk("addr_low", v, 8'h34);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk("irqs", {buffer_empty_irq, complete_irq}, 2'b00);
    lat <= 8'h28;
    seq(16'h0100, 8'h20, 1'b1);
    wait_out(1'b0);
    seq(16'h0102, 8'h20, 1'b1);
    rd(4'h2);
    chk("status", v, 8'h00);
    wait_out(1'b0);
    rd(4'h2);
    chk("status", v, 8'h80);
    drv(4'h0, 8'h00, 4'b0001);
    ns = n_start;
    seq(16'h0104, 8'h20, 1'b1);
    wr(4'h2, 8'h00);
    rd(4'h2);
    chk("status", v, 8'h90);
    wr(4'h2, 8'h10);
    wait_cc;
    chk("status", v, 8'hc0);
    chk("starts", n_start, ns);
    seq(16'h0200, 8'h40, 1'b1);
    wait_out(1'b0);
    seq(16'h0200, 8'h47, 1'b1);
    wait_out(1'b1);
    wait_cc;
    chk("status", v, 8'hd0);
    wr(4'h2, 8'h10);
    for (int j = 0; j < 2; j++) begin
      if (j == 0) seq(16'h0300, 8'h33, 1'b0);
      else drv(4'h0, 8'h00, 4'b0010);
      wr(4'h2, 8'h00);
      rd(4'h2);
      chk("status", v, 8'hd0);
      wr(4'h2, 8'h10);
    end
    special_mode_pin <= 1'b1;
    lat <= 8'h02;
    res_erased <= 1'b0;
    seq(16'h0000, 8'h05, 1'b1);
    wait_cc;
    chk("status", v, 8'hc2);
    wr(4'h2, 8'h02);
    res_erased <= 1'b1;
    seq(16'h0000, 8'h05, 1'b1);
    wait_cc;
    chk("status", v, 8'hc4);
    seq(16'h0006, 8'h20, 1'b1);
    wait_cc;
    chk("status", v, 8'hc0);
    wr(4'h8, 8'h80);
    ns = n_start;
    seq(16'h9000, 8'h20, 1'b1);
    wr(4'h2, 8'h00);
    rd(4'h2);
    chk("status", v, 8'he0);
    seq(16'h0006, 8'h20, 1'b1);
    chk("starts", n_start, ns);
    wr(4'h2, 8'h30);
    rd(4'h2);
    chk("status", v, 8'hc0);
    lat <= 8'h28;
    res_error <= 1'b1;
    seq(16'h0000, 8'h05, 1'b1);
    wait_out(1'b0);
    seq(16'h0006, 8'h20, 1'b1);
    ns = n_start;
    wait_cc;
    chk("status", v, 8'hd4);
    chk("starts", n_start, ns);
    res_error <= 1'b0;
    wr(4'h2, 8'h10);
    rd(4'h2);
    chk("status", v, 8'hc4);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("nv_control", nv_control, 8'hff);
    resetn <= 1'b1;
    repeat (12) @(posedge mclk);
    rd(4'h8);
    chk("protect", v, 8'h00);
    results();
  end
endmodule : flash_command_status_flags_tb_top
